// ### rtl/dhi_map.svh
// constants of the display host controller: mode codes, link timing, register offsets
// assumes a 40 MHz system clock; included by the controller and the bench
// Operation
// - 8-bit uses D[7:0], 16-bit D[15:0], 18-bit all; host ties unused lines low (parallel modes here leave them undriven)
// - 6800: read/write select low for write, high for read
// - parallel: command/data select low means command or status, high means RAM data
// - 6800: enable strobe latches while chip select low, captured on its falling edge
// - parallel: one dummy read discarded before first real RAM data read
// - 8080: read completes on read strobe rising edge, chip select low, write high
// - 8080: write captured on write strobe rising edge, chip select low, read high
// - 4-wire: write-strobe pin is serial clock, D0 serial in, D1 open, rest ground
// - 3-wire: D0 serial clock, D1 serial in, D2 open, others may be grounded
// - 3-wire: command/data select pin tied low, selection carried in-band
// - 3-wire: nine bits per transfer, flag first then byte most significant first
`ifndef DHI_MAP_SVH
`define DHI_MAP_SVH
// interface selection low bits
`define DHI_SEL_SPI4 2'h0
`define DHI_SEL_SPI3 2'h1
`define DHI_SEL_8080 2'h2
`define DHI_SEL_6800 2'h3
// upper selection bits: 00 8-bit, 01 16-bit, 11 18-bit
`define DHI_UP_W8 2'h0
`define DHI_UP_W16 2'h1
`define DHI_UP_W18 2'h3
`define DHI_UP_RESET 2'h0
// command that loads the upper selection bits
`define DHI_CMD_IFSEL 8'hab
// link timing: half period of strobes and serial clock, in ns
`define DHI_HALF_NS 100
`define DHI_CLK_NS 25
`define DHI_HALF_CYC ((`DHI_HALF_NS + `DHI_CLK_NS - 1) / `DHI_CLK_NS)
// reset pulse width in ns
`define DHI_RST_NS 2000
`define DHI_RST_CYC ((`DHI_RST_NS + `DHI_CLK_NS - 1) / `DHI_CLK_NS)
// wishbone register byte offsets
`define DHI_REG_CTRL 4'h0
`define DHI_REG_WDATA 4'h4
`define DHI_REG_STAT 4'h8
`define DHI_REG_RDATA 4'hc
// ctrl fields
`define DHI_CTRL_DC 0
`define DHI_CTRL_RD 1
`define DHI_CTRL_DUMMY 2
`define DHI_CTRL_RST 3
`define DHI_CTRL_UP_LO 4
// stat fields
`define DHI_STAT_BUSY 0
`define DHI_STAT_ERR 1
`define DHI_STAT_STRAP_LO 2
`define DHI_STAT_UP_LO 4
`endif

// ### rtl/dhi_pkg.sv
// types of the display host controller
// assumes dhi_map.svh alongside
package dhi_pkg;
	typedef enum logic [5:0]
	{
		DHI_IDLE = 6'h01,
		DHI_SETUP = 6'h02,
		DHI_ACT = 6'h04,
		DHI_HOLD = 6'h08,
		DHI_RSTP = 6'h10,
		DHI_DONE = 6'h20
	} dhi_state_t;
	typedef enum logic [2:0]
	{
		DHI_M_SPI4,
		DHI_M_SPI3,
		DHI_M_8080,
		DHI_M_6800
	} dhi_mode_t;
endpackage

// ### rtl/dhi_wb_if.sv
// wishbone register access between slave front end and controller core
// assumes one clock domain, i_sys_clk
`timescale 1ns/1ps
interface dhi_wb_if;
	logic wr;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport slave(output wr, output addr, output wdata, input rdata);
	modport core(input wr, input addr, input wdata, output rdata);
endinterface

// ### rtl/dhi_wb_slave.sv
// classic wishbone slave front end: one-cycle ack, reads from core rdata
// assumes single clock domain and a master that holds request until ack
`timescale 1ns/1ps
module dhi_wb_slave
(
	// system
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// wishbone
	input wire logic i_cyc,
	input wire logic i_stb,
	input wire logic i_we,
	input wire logic [3:0] i_adr,
	input wire logic [31:0] i_dat,
	output logic [31:0] o_dat,
	output logic o_ack,
	// core side
	dhi_wb_if.slave bus
);
	logic req;
	assign req = i_cyc && i_stb && !o_ack;
	assign bus.wr = req && i_we;
	assign bus.addr = i_adr;
	assign bus.wdata = i_dat;

	// ack one cycle after request, dropped the next; unmapped reads give zero in core
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_ack <= 1'b0;
		else
			o_ack <= req;
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_dat <= 32'h0;
		else if (req && !i_we)
			o_dat <= bus.rdata;
	end
endmodule // dhi_wb_slave

// ### rtl/dhi_host.sv
// host-side controller driving the display host port in parallel or serial modes
// assumes straps are static; device samples strobes slower than 40 MHz
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "dhi_map.svh"
module dhi_host
	import dhi_pkg::*;
#(
	parameter int HALF_CYC = `DHI_HALF_CYC,
	parameter int RST_CYC = `DHI_RST_CYC
)
(
	// system
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// wishbone
	input wire logic i_cyc,
	input wire logic i_stb,
	input wire logic i_we,
	input wire logic [3:0] i_adr,
	input wire logic [31:0] i_dat,
	output logic [31:0] o_dat,
	output logic o_ack,
	// strap levels the board gives the device
	input wire logic [1:0] i_iface_strap_pins,
	// device control pins
	output logic o_cs_n,
	output logic o_dc,
	output logic o_rw_wr,
	output logic o_e_rd,
	output logic o_reset_n,
	// device data pins
	input wire logic [17:0] i_d,
	output logic [17:0] o_d,
	output logic [17:0] o_d_oe
);
	dhi_wb_if wbi();
	dhi_state_t state;
	dhi_mode_t mode;
	logic [1:0] strap_s1;
	logic [1:0] strap_s2;
	logic [17:0] din_s1;
	logic [17:0] din_s2;
	logic [1:0] up_sel;
	logic cur_dc;
	logic cur_rd;
	logic cur_rst;
	logic busy;
	logic err;
	logic [17:0] wdata;
	logic [17:0] rdata;
	logic [15:0] tcnt;
	logic [3:0] bitn;
	logic [8:0] shreg;
	logic [3:0] nbits;
	logic go;
	logic tick;
	logic [17:0] wmask;
	logic prev_ifsel;

	dhi_wb_slave u_slave
	(
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_cyc(i_cyc),
		.i_stb(i_stb),
		.i_we(i_we),
		.i_adr(i_adr),
		.i_dat(i_dat),
		.o_dat(o_dat),
		.o_ack(o_ack),
		.bus(wbi)
	);

	// strap pins come from the board, so synchronise before decoding
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			strap_s1 <= 2'h0;
			strap_s2 <= 2'h0;
			din_s1 <= 18'h0;
			din_s2 <= 18'h0;
		end
		else
		begin
			strap_s1 <= i_iface_strap_pins;
			strap_s2 <= strap_s1;
			din_s1 <= i_d;
			din_s2 <= din_s1;
		end
	end

	function automatic dhi_mode_t decode_mode(input logic [1:0] lo);
		unique case (lo)
			`DHI_SEL_SPI4: decode_mode = DHI_M_SPI4;
			`DHI_SEL_SPI3: decode_mode = DHI_M_SPI3;
			`DHI_SEL_8080: decode_mode = DHI_M_8080;
			default: decode_mode = DHI_M_6800;
		endcase
	endfunction

	// width mask follows the upper selection bits; illegal 10 falls back to 8-bit
	function automatic logic [17:0] width_mask(input logic [1:0] up);
		unique case (up)
			`DHI_UP_W18: width_mask = 18'h3ffff;
			`DHI_UP_W16: width_mask = 18'h0ffff;
			default: width_mask = 18'h000ff;
		endcase
	endfunction

	assign mode = decode_mode(strap_s2);
	assign wmask = width_mask(up_sel);
	assign tick = (tcnt == 16'h0);
	assign go = wbi.wr && (wbi.addr == `DHI_REG_WDATA) && !busy;

	// register reads
	always_comb
	begin
		wbi.rdata = 32'h0;
		unique case (wbi.addr)
			`DHI_REG_CTRL: wbi.rdata = {26'h0, up_sel, cur_rst, 1'b0, cur_rd, cur_dc};
			`DHI_REG_STAT: wbi.rdata = {26'h0, up_sel, strap_s2, err, busy};
			`DHI_REG_RDATA: wbi.rdata = {14'h0, rdata};
			default: wbi.rdata = 32'h0;
		endcase
	end

	// control register
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cur_dc <= 1'b0;
			cur_rd <= 1'b0;
			cur_rst <= 1'b0;
		end
		else if (wbi.wr && wbi.addr == `DHI_REG_CTRL && !busy)
		begin
			cur_dc <= wbi.wdata[`DHI_CTRL_DC];
			cur_rd <= wbi.wdata[`DHI_CTRL_RD] | wbi.wdata[`DHI_CTRL_DUMMY];
			cur_rst <= wbi.wdata[`DHI_CTRL_RST];
		end
	end

	// shadow of the device's upper selection bits, tracks the select command
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			up_sel <= `DHI_UP_RESET;
		else if (state == DHI_RSTP)
			up_sel <= `DHI_UP_RESET;
		else if (state == DHI_DONE && !cur_dc && !cur_rd && prev_ifsel)
			up_sel <= wdata[1:0];
	end

	// the selection command is followed by its one argument byte
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			prev_ifsel <= 1'b0;
		else if (state == DHI_RSTP)
			prev_ifsel <= 1'b0;
		else if (state == DHI_DONE && !cur_rd)
			prev_ifsel <= !cur_dc && (wdata[7:0] == `DHI_CMD_IFSEL) && !prev_ifsel;
	end

	// error: read requested in a serial mode is refused
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			err <= 1'b0;
		else if (go && cur_rd && (mode == DHI_M_SPI4 || mode == DHI_M_SPI3))
			err <= 1'b1;
		else if (go)
			err <= 1'b0;
	end

	// phase timer
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			tcnt <= 16'h0;
		else if (state == DHI_IDLE && go)
			tcnt <= cur_rst ? 16'(RST_CYC - 1) : 16'(HALF_CYC - 1);
		else if (tick)
			tcnt <= 16'(HALF_CYC - 1);
		else
			tcnt <= tcnt - 16'h1;
	end

	// transfer sequencer
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			state <= DHI_IDLE;
			busy <= 1'b0;
			wdata <= 18'h0;
		end
		else
		begin
			unique case (state)
				DHI_IDLE:
					if (go && !(cur_rd && (mode == DHI_M_SPI4 || mode == DHI_M_SPI3)))
					begin
						busy <= 1'b1;
						wdata <= wbi.wdata[17:0] & wmask;
						state <= cur_rst ? DHI_RSTP : DHI_SETUP;
					end
				DHI_RSTP:
					if (tick)
						state <= DHI_DONE;
				DHI_SETUP:
					if (tick)
						state <= DHI_ACT;
				DHI_ACT:
					if (tick)
						state <= DHI_HOLD;
				DHI_HOLD:
					if (tick)
						state <= (mode == DHI_M_SPI4 || mode == DHI_M_SPI3) && bitn + 4'h1 != nbits ? DHI_ACT : DHI_DONE;
				DHI_DONE:
				begin
					busy <= 1'b0;
					state <= DHI_IDLE;
				end
				default: state <= DHI_IDLE;
			endcase
		end
	end

	// serial bit counter restarts each transfer, mirroring the device's cs-high clear
	assign nbits = (mode == DHI_M_SPI3) ? 4'd9 : 4'd8;
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			bitn <= 4'h0;
			shreg <= 9'h0;
		end
		else if (state == DHI_IDLE && go)
		begin
			bitn <= 4'h0;
			if (mode == DHI_M_SPI3)
				shreg <= {cur_dc, wbi.wdata[7:0]};
			else
				shreg <= {wbi.wdata[7:0], 1'b0};
		end
		else if (state == DHI_HOLD && tick)
		begin
			bitn <= bitn + 4'h1;
			shreg <= {shreg[7:0], 1'b0};
		end
	end

	// read data taken on the sample edge; first data read after address is a dummy
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			rdata <= 18'h0;
		else if (state == DHI_ACT && tick && cur_rd)
			rdata <= din_s2 & wmask;
	end

	// pin drive
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_cs_n <= 1'b1;
			o_dc <= 1'b0;
			o_rw_wr <= 1'b1;
			o_e_rd <= 1'b1;
			o_reset_n <= 1'b1;
			o_d <= 18'h0;
			o_d_oe <= 18'h0;
		end
		else
		begin
			o_reset_n <= !(state == DHI_RSTP);
			o_cs_n <= !(state == DHI_SETUP || state == DHI_ACT || state == DHI_HOLD);
			unique case (mode)
				DHI_M_6800:
				begin
					o_dc <= cur_dc;
					o_rw_wr <= cur_rd;
					o_e_rd <= (state == DHI_ACT);
					o_d <= wdata;
					o_d_oe <= cur_rd || state == DHI_IDLE ? 18'h0 : wmask;
				end
				DHI_M_8080:
				begin
					o_dc <= cur_dc;
					o_rw_wr <= !(state == DHI_ACT && !cur_rd);
					o_e_rd <= !(state == DHI_ACT && cur_rd);
					o_d <= wdata;
					o_d_oe <= cur_rd || state == DHI_IDLE ? 18'h0 : wmask;
				end
				DHI_M_SPI4:
				begin
					o_dc <= cur_dc;
					o_rw_wr <= (state == DHI_HOLD);
					o_e_rd <= 1'b0;
					o_d <= {17'h0, shreg[8]};
					o_d_oe <= 18'h3fffd;
				end
				default:
				begin
					o_dc <= 1'b0;
					o_rw_wr <= 1'b0;
					o_e_rd <= 1'b0;
					o_d <= {16'h0, shreg[8], state == DHI_HOLD};
					o_d_oe <= 18'h3fffb;
				end
			endcase
		end
	end

	property p_cs_idle;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state == DHI_IDLE) |=> o_cs_n;
	endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("chip select active while idle");

	property p_rd_no_drive;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(cur_rd && (mode == DHI_M_8080 || mode == DHI_M_6800)) |=> (o_d_oe == 18'h0);
	endproperty
	a_rd_no_drive: assert property (p_rd_no_drive) else $error("data driven during read");

	property p_8080_excl;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(mode == DHI_M_8080) |=> (o_rw_wr || o_e_rd);
	endproperty
	a_8080_excl: assert property (p_8080_excl) else $error("both 8080 strobes low");

	property p_serial_no_read;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(go && cur_rd && mode == DHI_M_SPI4) |=> (state == DHI_IDLE && err);
	endproperty
	a_serial_no_read: assert property (p_serial_no_read) else $error("serial read accepted");

	property p_spi3_dc_low;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(mode == DHI_M_SPI3 && $past(mode) == DHI_M_SPI3) |-> !o_dc;
	endproperty
	a_spi3_dc_low: assert property (p_spi3_dc_low) else $error("dc pin not low in 3-wire");

	property p_up_reset;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state == DHI_RSTP) |=> (up_sel == `DHI_UP_RESET);
	endproperty
	a_up_reset: assert property (p_up_reset) else $error("upper bits not cleared by reset");

	property p_reset_pin;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state == DHI_RSTP) |=> !o_reset_n;
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin not low");

	property p_bits_bound;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(busy) |-> (bitn <= nbits);
	endproperty
	a_bits_bound: assert property (p_bits_bound) else $error("too many serial bits");

	property p_d1_open;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(mode == DHI_M_SPI4 && $past(mode) == DHI_M_SPI4) |-> !o_d_oe[1];
	endproperty
	a_d1_open: assert property (p_d1_open) else $error("data line one driven in 4-wire");
endmodule // dhi_host

// ### verif/dhi_dev_model.sv
// behavioural display device at the far end of the host port
// assumes the bench resolves the shared data lines
`timescale 1ns/1ps
module dhi_dev_model
#(
	parameter logic [17:0] RD_VAL = 18'h2d5a3
)
(
	// straps and control pins
	input wire logic [1:0] i_strap,
	input wire logic i_cs_n,
	input wire logic i_dc,
	input wire logic i_rw_wr,
	input wire logic i_e_rd,
	input wire logic i_reset_n,
	// data lines
	input wire logic [17:0] i_d,
	output logic [17:0] o_d
);
	logic [1:0] up = 2'h0;
	logic [17:0] pipe = 18'h0;
	logic [8:0] sh = 9'h0;
	logic ab = 1'b0;
	logic rd_act;
	logic [17:0] rdv;
	logic [17:0] cap_w = 18'h0;
	logic cap_dc = 1'b0;
	int cnt = 0;
	int edges = 0;
	int frame_bits = 0;
	int cap_n = 0;
	int rst_seen = 0;
	task cap(input logic [17:0] w, input logic c);
		cap_w = w & (up == 2'h1 ? 18'hffff : up == 2'h3 ? 18'h3ffff : 18'hff);
		cap_dc = c;
		cap_n++;
		pipe = ~RD_VAL;
		if (!c)
		begin
			if (ab)
				up = w[1:0];
			ab = w[7:0] == 8'hab;
		end
	endtask
	// a released line shows the inverse, so a stale value never passes
	assign rd_act = !i_cs_n && (i_strap == 2'h2 ? !i_e_rd : i_strap == 2'h3 && i_rw_wr && i_e_rd);
	assign rdv = i_dc ? pipe : {16'h0, up};
	assign o_d = rd_act ? rdv : ~rdv;
	always @(negedge i_reset_n)
	begin
		up = 2'h0;
		ab = 1'b0;
		rst_seen++;
	end
	always @(posedge i_rw_wr)
	begin
		if (!i_cs_n && i_e_rd && i_strap == 2'h2)
			cap(i_d, i_dc);
		if (!i_cs_n && i_strap == 2'h0)
		begin
			sh = {sh[7:0], i_d[0]};
			edges++;
			cnt++;
			if (cnt == 8)
			begin
				cap({10'h0, sh[7:0]}, i_dc);
				cnt = 0;
			end
		end
	end
	always @(posedge i_e_rd)
	begin
		if (!i_cs_n && i_rw_wr && i_strap == 2'h2 && i_dc)
			pipe = RD_VAL;
	end
	always @(negedge i_e_rd)
	begin
		if (!i_cs_n && i_strap == 2'h3)
		begin
			if (!i_rw_wr)
				cap(i_d, i_dc);
			else if (i_dc)
				pipe = RD_VAL;
		end
	end
	always @(posedge i_d[0])
	begin
		if (!i_cs_n && i_strap == 2'h1)
		begin
			sh = {sh[7:0], i_d[1]};
			edges++;
			cnt++;
			if (cnt == 9)
			begin
				cap({10'h0, sh[7:0]}, sh[8]);
				cnt = 0;
			end
		end
	end
	// serial clocks seen in the frame that just ended
	always @(posedge i_cs_n)
	begin
		frame_bits = edges;
		edges = 0;
		cnt = 0;
	end
endmodule // dhi_dev_model

// ### verif/display_host_interface_tb_top.sv
// self-checking bench of the display host controller against a device model
// assumes dhi_map.svh on the include path
`timescale 1ns/1ps
`include "dhi_map.svh"
module display_host_interface_tb_top;
	localparam logic [17:0] RD_VAL = 18'h2d5a3;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [1:0] strap = 2'h0;
	logic [31:0] rdat;
	logic ack;
	logic cs_n;
	logic dc;
	logic rw_wr;
	logic e_rd;
	logic reset_n;
	logic [17:0] d_out;
	logic [17:0] d_oe;
	logic [17:0] dev_d;
	logic [17:0] bus;
	logic [31:0] q;
	logic [17:0] w;
	logic [1:0] up_exp = 2'h0;
	logic dcb;
	int n0;
	int failures = 0;
	int checks_done = 0;
	int seed = 52;
	assign bus = (d_out & d_oe) | (dev_d & ~d_oe);
	dhi_host #(.HALF_CYC(4), .RST_CYC(8)) DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_cyc(cyc), .i_stb(stb),
		.i_we(we), .i_adr(adr), .i_dat(wdat), .o_dat(rdat), .o_ack(ack), .i_iface_strap_pins(strap),
		.o_cs_n(cs_n), .o_dc(dc), .o_rw_wr(rw_wr), .o_e_rd(e_rd), .o_reset_n(reset_n), .i_d(bus),
		.o_d(d_out), .o_d_oe(d_oe));
	dhi_dev_model #(.RD_VAL(RD_VAL)) model (.i_strap(strap), .i_cs_n(cs_n), .i_dc(dc), .i_rw_wr(rw_wr),
		.i_e_rd(e_rd), .i_reset_n(reset_n), .i_d(bus), .o_d(dev_d));
	initial forever #12.5 clk = ~clk;
	function automatic logic [17:0] wmask(input logic [1:0] s, input logic [1:0] u);
		if (s < 2'h2)
			return 18'hff;
		return u == 2'h1 ? 18'hffff : u == 2'h3 ? 18'h3ffff : 18'hff;
	endfunction
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 100);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 100)
		begin
			failures++;
			test_done();
		end
	endtask
	// ctrl carries the expected upper bits so either reading of them holds
	task go(input logic [3:0] f, input logic [17:0] d);
		int n;
		wb(1'b1, `DHI_REG_CTRL, {26'h0, up_exp, f});
		wb(1'b1, `DHI_REG_WDATA, {14'h0, d});
		n = 0;
		do
		begin
			wb(1'b0, `DHI_REG_STAT, 32'h0);
			n++;
		end
		while (q[`DHI_STAT_BUSY] !== 1'b0 && n < 200);
		if (n >= 200)
		begin
			failures++;
			test_done();
		end
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, `DHI_REG_STAT, 32'h0);
		chk("stat", 32'h0, q);
		chk("idle cs", 32'h1, {31'h0, cs_n});
		chk("idle oe", 32'h3fffd, {14'h0, d_oe});
		for (int m = 0; m < 4; m++)
		begin
			strap <= m[1:0];
			repeat (4) @(posedge clk);
			for (int k = 0; k < 6; k++)
			begin
				w = 18'($random(seed));
				dcb = 1'($random(seed));
				if (k == 0)
					w = 18'h3ffff;
				if (w[7:0] == 8'hab)
					w[7:0] = 8'h5a;
				n0 = model.cap_n;
				go({3'h0, dcb}, w);
				chk("count", n0 + 1, model.cap_n);
				chk("word", {14'h0, w & wmask(strap, up_exp)}, {14'h0, model.cap_w});
				chk("dc", {31'h0, dcb}, {31'h0, model.cap_dc});
				if (m < 2)
					chk("serial clocks", m == 1 ? 9 : 8, model.frame_bits);
			end
			$display("test writes in mode %0d done", m);
		end
		strap <= 2'h0;
		repeat (4) @(posedge clk);
		n0 = model.cap_n;
		go(4'h2, 18'h0);
		chk("serial read err", 32'h1, {31'h0, q[`DHI_STAT_ERR]});
		chk("serial read silent", n0, model.cap_n);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test refusals done");
		for (int m = 2; m < 4; m++)
		begin
			strap <= m[1:0];
			repeat (4) @(posedge clk);
			go(4'h1, 18'h15);
			go(4'h7, 18'h0);
			wb(1'b0, `DHI_REG_RDATA, 32'h0);
			chk("dummy", {14'h0, ~RD_VAL & 18'hff}, q & 32'hff);
			go(4'h3, 18'h0);
			wb(1'b0, `DHI_REG_RDATA, 32'h0);
			chk("rdata", {14'h0, RD_VAL & 18'hff}, q & 32'hff);
		end
		$display("test reads done");
		for (int u = 1; u < 4; u += 2)
		begin
			go(4'h0, 18'hab);
			go(4'h0, 18'(u));
			up_exp = 2'(u);
			wb(1'b0, `DHI_REG_STAT, 32'h0);
			chk("upper", 32'(u), {30'h0, q[`DHI_STAT_UP_LO+:2]});
			w = 18'($random(seed));
			go(4'h1, w);
			chk("wide word", {14'h0, w & wmask(strap, up_exp)}, {14'h0, model.cap_w});
		end
		n0 = model.rst_seen;
		go(4'h8, 18'h0);
		up_exp = 2'h0;
		chk("reset pulse", n0 + 1, model.rst_seen);
		wb(1'b0, `DHI_REG_STAT, 32'h0);
		chk("upper cleared", 32'h0, {30'h0, q[`DHI_STAT_UP_LO+:2]});
		chk("reset released", 32'h1, {31'h0, reset_n});
		$display("test width and reset done");
		test_done();
	end
endmodule // display_host_interface_tb_top
